// >>> logic/sec_err_log_map.svh
// Purpose: Offsets, field widths and reset values of the secondary error log registers.
// Assumes: Byte offsets in the extended configuration space, one 32-bit word each.
// Notes: Definitions only.
`ifndef SEC_ERR_LOG_MAP_SVH
`define SEC_ERR_LOG_MAP_SVH
`define OFS_CAP_CTRL 12'h138
`define OFS_LOG_WORD0 12'h13c
`define OFS_LOG_WORD1 12'h140
`define OFS_LOG_WORD2 12'h144
`define OFS_LOG_WORD3 12'h148
`define PTR_WIDTH 5
`define CMD_WIDTH 4
`define STATUS_WIDTH 32
`define ZERO_WORD 32'h0000_0000
`define ZERO_PTR 5'h00
`define ZERO_CMD 4'h0
`define ZERO_ATTR 36'h0_0000_0000
`define ZERO_RSVD_LOG 20'h0_0000
`define ZERO_RSVD_PTR 27'h000_0000
`endif

// >>> logic/sec_err_log_pkg.sv
// Purpose: Types shared by the secondary error log block.
// Assumes: Nothing beyond the map header.
// Notes: Holds the read selector enumeration.
package sec_err_log_pkg;
  typedef enum logic [2:0] {
    sel_none,
    sel_cap,
    sel_w0,
    sel_w1,
    sel_w2,
    sel_w3
  } read_sel_t;
endpackage : sec_err_log_pkg

// >>> logic/sync_pair.sv
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: Destination clock is mclk.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps
module sync_pair (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : sync_pair

// >>> logic/sec_err_log.sv
// Purpose: First error pointer and 128-bit header log of the secondary PCI side.
// Assumes: Capture strobes come from bridge logic on mclk; reset pins are asynchronous.
// Notes: Reads return data one cycle after the read strobe.
// Behaviour
// - A 5-bit read-only pointer in bits 4:0 names the status bit of the first error class.
// - Each detected error captures the address and command of its bus cycle, newest wins.
// - The log reads as four words at 13Ch, 140h, 144h and 148h, low slice first.
// - The first address phase goes to bits 95:64 and the second to bits 127:96.
// - A single 32-bit address phase forces bits 127:96 to zero.
// - For a dual-address cycle the second phase command goes to bits 43:40.
// - The first address phase command goes to bits 39:36.
// - Bits 35:0 have no function and read as zero.
// - Reserved bits 63:44 of the log and 31:5 of the pointer register read as zero.
// - Both registers are read-only and reset to all zeros.
// - Fundamental reset, the global reset input or power-on reset clears the fields.
`timescale 1ns/100ps
`include "sec_err_log_map.svh"
module sec_err_log
  import sec_err_log_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic perst_n,
  input wire logic global_reset_input,
  input wire logic err_valid,
  input wire logic [`PTR_WIDTH-1:0] err_class,
  input wire logic err_dual_addr,
  input wire logic [31:0] err_addr_lo,
  input wire logic [31:0] err_addr_hi,
  input wire logic [`CMD_WIDTH-1:0] err_cmd_lo,
  input wire logic [`CMD_WIDTH-1:0] err_cmd_hi,
  input wire logic [`STATUS_WIDTH-1:0] uncor_status,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [`PTR_WIDTH-1:0] first_fault_class_index
);
  logic perst_s;
  logic global_reset_input_s;
  logic soft_clr;
  logic [`PTR_WIDTH-1:0] ptr_reg;
  logic [`PTR_WIDTH-1:0] ptr_next;
  logic ptr_valid_reg;
  logic ptr_valid_next;
  logic [31:0] addr_lo_reg;
  logic [31:0] addr_lo_next;
  logic [31:0] addr_hi_reg;
  logic [31:0] addr_hi_next;
  logic [`CMD_WIDTH-1:0] cmd_lo_reg;
  logic [`CMD_WIDTH-1:0] cmd_lo_next;
  logic [`CMD_WIDTH-1:0] cmd_hi_reg;
  logic [`CMD_WIDTH-1:0] cmd_hi_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [127:0] log_word;
  read_sel_t sel;

  // The perst_n and global_reset_input pins are asynchronous to mclk and are synchronised first; nrst is used directly.
  sync_pair u_sync_perst (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(~perst_n),
    .sync_out(perst_s)
  );

  sync_pair u_sync_global_reset_input (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(global_reset_input),
    .sync_out(global_reset_input_s)
  );

  assign soft_clr = perst_s | global_reset_input_s;

  always_comb
  begin
    ptr_next = ptr_reg;
    ptr_valid_next = ptr_valid_reg;
    addr_lo_next = addr_lo_reg;
    addr_hi_next = addr_hi_reg;
    cmd_lo_next = cmd_lo_reg;
    cmd_hi_next = cmd_hi_reg;
    if (soft_clr)
    begin
      ptr_next = `ZERO_PTR;
      ptr_valid_next = 1'b0;
      addr_lo_next = `ZERO_WORD;
      addr_hi_next = `ZERO_WORD;
      cmd_lo_next = `ZERO_CMD;
      cmd_hi_next = `ZERO_CMD;
    end
    else
    begin
      if (ptr_valid_reg && !uncor_status[ptr_reg])
      begin
        ptr_valid_next = 1'b0;
      end
      if (err_valid)
      begin
        if (!ptr_valid_reg || !uncor_status[ptr_reg])
        begin
          ptr_next = err_class;
          ptr_valid_next = 1'b1;
        end
        addr_lo_next = err_addr_lo;
        cmd_lo_next = err_cmd_lo;
        addr_hi_next = err_dual_addr ? err_addr_hi : `ZERO_WORD;
        cmd_hi_next = err_dual_addr ? err_cmd_hi : `ZERO_CMD;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_reg <= `ZERO_PTR;
      ptr_valid_reg <= 1'b0;
      addr_lo_reg <= `ZERO_WORD;
      addr_hi_reg <= `ZERO_WORD;
      cmd_lo_reg <= `ZERO_CMD;
      cmd_hi_reg <= `ZERO_CMD;
    end
    else
    begin
      ptr_reg <= ptr_next;
      ptr_valid_reg <= ptr_valid_next;
      addr_lo_reg <= addr_lo_next;
      addr_hi_reg <= addr_hi_next;
      cmd_lo_reg <= cmd_lo_next;
      cmd_hi_reg <= cmd_hi_next;
    end
  end

  assign log_word = {addr_hi_reg, addr_lo_reg, `ZERO_RSVD_LOG, cmd_hi_reg, cmd_lo_reg,
                     `ZERO_ATTR};

  always_comb
  begin
    unique case (cfg_addr)
      `OFS_CAP_CTRL: sel = sel_cap;
      `OFS_LOG_WORD0: sel = sel_w0;
      `OFS_LOG_WORD1: sel = sel_w1;
      `OFS_LOG_WORD2: sel = sel_w2;
      `OFS_LOG_WORD3: sel = sel_w3;
      default: sel = sel_none;
    endcase
  end

  always_comb
  begin
    rvalid_next = cfg_rd;
    rdata_next = `ZERO_WORD;
    if (cfg_rd)
    begin
      unique case (sel)
        sel_cap: rdata_next = {`ZERO_RSVD_PTR, ptr_reg};
        sel_w0: rdata_next = log_word[31:0];
        sel_w1: rdata_next = log_word[63:32];
        sel_w2: rdata_next = log_word[95:64];
        sel_w3: rdata_next = log_word[127:96];
        sel_none: rdata_next = `ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= `ZERO_WORD;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_rvalid = rvalid_reg;
  assign first_fault_class_index = ptr_reg;

  sequence s_err_single;
    err_valid && !err_dual_addr && !soft_clr;
  endsequence

  sequence s_rd_word3;
    cfg_rd && (cfg_addr == `OFS_LOG_WORD3);
  endsequence

  a_write_ignored: assert property (@(posedge mclk) disable iff (!nrst)
    (cfg_wr && !err_valid && !soft_clr && !(ptr_valid_reg && !uncor_status[ptr_reg]))
    |=> $stable(log_word) && $stable(ptr_reg))
    else $error("register changed on a write");

  // High word zero after single phase capture.
  a_single_hi_zero: assert property (@(posedge mclk) disable iff (!nrst)
    s_err_single |=> log_word[127:96] == `ZERO_WORD)
    else $error("upper address not zero");

  // Upper word read returns the second phase slice.
  a_rd_word3: assert property (@(posedge mclk) disable iff (!nrst)
    s_rd_word3 |=> cfg_rdata == $past(log_word[127:96]))
    else $error("upper word read mismatch");

  a_capture_lo: assert property (@(posedge mclk) disable iff (!nrst)
    (err_valid && !soft_clr) |=> addr_lo_reg == $past(err_addr_lo) &&
    cmd_lo_reg == $past(err_cmd_lo))
    else $error("capture missed");

  a_dual_hi: assert property (@(posedge mclk) disable iff (!nrst)
    (err_valid && err_dual_addr && !soft_clr) |=> log_word[127:96] == $past(err_addr_hi))
    else $error("second address misplaced");

  a_cmd_hi: assert property (@(posedge mclk) disable iff (!nrst)
    (err_valid && err_dual_addr && !soft_clr) |=> log_word[43:40] == $past(err_cmd_hi))
    else $error("upper command misplaced");

  a_cmd_lo: assert property (@(posedge mclk) disable iff (!nrst)
    (err_valid && !soft_clr) |=> log_word[39:36] == $past(err_cmd_lo))
    else $error("lower command misplaced");

  // Attribute bits 31:0 of log word 0 read zero.
  a_zero_fields: assert property (@(posedge mclk) disable iff (!nrst)
    (cfg_rd && (cfg_addr == `OFS_LOG_WORD0)) |=> cfg_rdata == `ZERO_WORD ##0 cfg_rvalid)
    else $error("attribute field not zero");

  a_ptr_rsvd: assert property (@(posedge mclk) disable iff (!nrst)
    cfg_rvalid |-> cfg_rdata[31:5] == `ZERO_RSVD_PTR || $past(cfg_addr) != `OFS_CAP_CTRL)
    else $error("pointer reserved bits set");

  // Pointer holds while its status bit is set.
  a_ptr_hold: assert property (@(posedge mclk) disable iff (!nrst)
    (ptr_valid_reg && uncor_status[ptr_reg] && !soft_clr) |=> $stable(ptr_reg))
    else $error("pointer overwritten");

  a_soft_clear: assert property (@(posedge mclk) disable iff (!nrst)
    soft_clr |=> ptr_reg == `ZERO_PTR && log_word == 128'h0)
    else $error("reset source did not clear");

  a_ptr_first: assert property (@(posedge mclk) disable iff (!nrst)
    (err_valid && !ptr_valid_reg && !soft_clr) |=> ptr_reg == $past(err_class))
    else $error("pointer missed first error");

  a_read_timing: assert property (@(posedge mclk) disable iff (!nrst)
    cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
endmodule : sec_err_log

// >>> testbench/sec_err_log_bench.sv
// Purpose: Self-checking bench for the secondary error log block.
// Assumes: Read data and its valid pulse appear one cycle after the read strobe.
// Notes: Inputs change by non-blocking assignment at the rising edge, except uncor_status, which is set 1 ns after an edge.
`timescale 1ns/100ps
`include "sec_err_log_map.svh"
module sec_err_log_bench;
  logic mclk, nrst, perst_n, global_reset_input, err_valid, err_dual_addr, cfg_rd, cfg_wr;
  logic [4:0] err_class;
  logic [31:0] err_addr_lo, err_addr_hi, uncor_status, cfg_rdata;
  logic [3:0] err_cmd_lo, err_cmd_hi;
  logic [11:0] cfg_addr;
  logic cfg_rvalid;
  logic [4:0] first_fault_class_index;
  int err_total, checked;

  sec_err_log sec_err_log_inst (.mclk, .nrst, .perst_n, .global_reset_input, .err_valid,
    .err_class, .err_dual_addr, .err_addr_lo, .err_addr_hi, .err_cmd_lo, .err_cmd_hi,
    .uncor_status, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_rdata, .cfg_rvalid,
    .first_fault_class_index);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    #1;
    check("read valid", {31'h0, cfg_rvalid}, 32'h1);
    check($sformatf("read data at %h", a), cfg_rdata, exp);
  endtask : rd

  task err(input logic [4:0] c, input logic d, input logic [31:0] lo, input logic [31:0] hi,
           input logic [3:0] cl, input logic [3:0] ch);
    @(posedge mclk);
    err_valid <= 1'b1;
    err_class <= c;
    err_dual_addr <= d;
    err_addr_lo <= lo;
    err_addr_hi <= hi;
    err_cmd_lo <= cl;
    err_cmd_hi <= ch;
    @(posedge mclk);
    err_valid <= 1'b0;
    #1;
  endtask : err

  task test_reset_values;
    for (int i = 0; i < 5; i++)
      rd(`OFS_CAP_CTRL + 12'(4 * i), 32'h0);
  endtask : test_reset_values

  task test_single;
    uncor_status <= 32'h0000_0008;
    err(5'h03, 1'b0, 32'h1234_5678, 32'hdead_beef, 4'h6, 4'hb);
    check("pointer", {27'h0, first_fault_class_index}, 32'h3);
    rd(`OFS_CAP_CTRL, 32'h0000_0003);
    rd(`OFS_LOG_WORD0, 32'h0);
    rd(`OFS_LOG_WORD1, 32'h0000_0060);
    rd(`OFS_LOG_WORD2, 32'h1234_5678);
    rd(`OFS_LOG_WORD3, 32'h0);
  endtask : test_single

  task test_dual;
    uncor_status <= 32'h0000_0008;
    err(5'h07, 1'b1, 32'h0bad_f00d, 32'h0000_00c1, 4'hd, 4'h7);
    rd(`OFS_CAP_CTRL, 32'h0000_0003);
    rd(`OFS_LOG_WORD1, 32'h0000_07d0);
    rd(`OFS_LOG_WORD2, 32'h0bad_f00d);
    rd(`OFS_LOG_WORD3, 32'h0000_00c1);
  endtask : test_dual

  task test_pointer_move;
    uncor_status <= 32'h0000_0000;
    err(5'h1f, 1'b1, 32'h0000_0100, 32'hffff_ffff, 4'hf, 4'h1);
    rd(`OFS_CAP_CTRL, 32'h0000_001f);
    rd(`OFS_LOG_WORD1, 32'h0000_01f0);
  endtask : test_pointer_move

  task test_refused;
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_addr <= `OFS_LOG_WORD2;
    @(posedge mclk);
    cfg_addr <= `OFS_CAP_CTRL;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    rd(`OFS_LOG_WORD2, 32'h0000_0100);
    rd(`OFS_CAP_CTRL, 32'h0000_001f);
    rd(12'h14c, 32'h0);
  endtask : test_refused

  task test_resets;
    @(posedge mclk);
    perst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    perst_n <= 1'b1;
    rd(`OFS_CAP_CTRL, 32'h0);
    rd(`OFS_LOG_WORD2, 32'h0);
    err(5'h0a, 1'b1, 32'h5555_aaaa, 32'h0f0f_0f0f, 4'h2, 4'h3);
    rd(`OFS_CAP_CTRL, 32'h0000_000a);
    @(posedge mclk);
    global_reset_input <= 1'b1;
    repeat (6) @(posedge mclk);
    global_reset_input <= 1'b0;
    rd(`OFS_LOG_WORD3, 32'h0);
    rd(`OFS_LOG_WORD1, 32'h0);
    err(5'h05, 1'b0, 32'h1, 32'h2, 4'h4, 4'h5);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    check("pointer in reset", {27'h0, first_fault_class_index}, 32'h0);
    nrst <= 1'b1;
    rd(`OFS_LOG_WORD2, 32'h0);
  endtask : test_resets

  initial
  begin
    repeat (2000) @(posedge mclk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    {nrst, global_reset_input, err_valid, err_dual_addr, cfg_rd, cfg_wr} = 6'h00;
    perst_n = 1'b1;
    {err_class, err_cmd_lo, err_cmd_hi, cfg_addr} = 25'h0;
    {err_addr_lo, err_addr_hi, uncor_status} = 96'h0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    test_reset_values();
    test_single();
    test_dual();
    test_pointer_move();
    test_refused();
    test_resets();
    print_verdict();
  end
endmodule : sec_err_log_bench
